//--- hdl/ruisc_top.sv
// The plain strobed port is this design's own decision.
`timescale 1ns/1ps
`include "ruisc_defs.svh"
// Request-unit and event interrupt status with clear and enable
module ruisc_top (
    // Clock, reset, enable
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // Register port
    input wire ruisc_pkg::ruisc_bus_s bus_i,
    output logic [31:0] rdata_o,
    // Request unit conditions
    input wire ruisc_pkg::ruisc_unit_evt_s [3:0] unit_evt_i,
    input wire logic [3:0] unit_irq_req_i,
    // Port and special events
    input wire ruisc_pkg::ruisc_evt_s evt_i,
    // Interrupt
    output logic irq_o
);
    logic [31:0] req_status_w;
    logic [31:0] evt_status_w;
    logic [31:0] evt_set_w;
    logic [7:0] evt_packed_w;
    logic [7:0] evt_flag_w;
    logic [31:0] rdata_nxt;
    logic [31:0] rdata_r;
    logic [1:0] irq_en_r;
    logic [1:0] summary_w;
    logic wr_req_clr_w;
    logic wr_evt_clr_w;
    logic wr_en_w;
    logic [31:0] req_clr_w;
    logic [31:0] evt_clr_w;
    logic [7:0] evt_clr_packed_w;

    // Address decode
    assign wr_req_clr_w = bus_i.wr && bus_i.addr == `RUISC_OFF_REQ_CLEAR;
    assign wr_evt_clr_w = bus_i.wr && bus_i.addr == `RUISC_OFF_EVT_CLEAR;
    assign wr_en_w = bus_i.wr && bus_i.addr == `RUISC_OFF_IRQ_ENABLE;

    // Ones clear, zeros leave alone
    assign req_clr_w = wr_req_clr_w ? bus_i.wdata : 32'h0000_0000;
    assign evt_clr_w = wr_evt_clr_w ? (bus_i.wdata & `RUISC_EVT_MASK) : 32'h0000_0000;

    // Unit n owns byte n
    genvar g;
    generate
        for (g = 0; g < 4; g++)
        begin : g_unit
            ruisc_unit u_unit (
                .sys_clk_i(sys_clk_i),
                .rst_i(rst_i),
                .ce_i(ce_i),
                .evt_i(unit_evt_i[g]),
                .irq_req_i(unit_irq_req_i[g]),
                .clr_i(req_clr_w[8*g +: 8]),
                .flag_o(req_status_w[8*g +: 8])
            );
        end
    endgenerate

    // Events packed into eight flags, then spread to their bit positions
    assign evt_packed_w = {evt_i.reset_req, evt_i.port_error, evt_i.capture,
        evt_i.port_write_in, evt_i.mcast_event};
    assign evt_clr_packed_w = {evt_clr_w[`RUISC_EVT_RESET_BIT],
        evt_clr_w[`RUISC_EVT_PORT_LSB +: 4], evt_clr_w[`RUISC_EVT_CAPTURE_BIT],
        evt_clr_w[`RUISC_EVT_PWIN_BIT], evt_clr_w[`RUISC_EVT_MCAST_BIT]};

    ruisc_sticky #(.W(8)) u_evt (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .set_i(evt_packed_w),
        .clr_i(evt_clr_packed_w),
        .flag_o(evt_flag_w)
    );

    // Reserved bits stay zero
    assign evt_set_w = {15'h0000, evt_flag_w[7], 4'h0, evt_flag_w[6:3], 5'h00,
        evt_flag_w[2:0]};
    assign evt_status_w = evt_set_w & `RUISC_EVT_MASK;

    assign summary_w = {|evt_status_w, |req_status_w};
    assign irq_o = |(summary_w & irq_en_r);

    // Read mux; write-only and unmapped read zero
    assign rdata_nxt =
        (bus_i.addr == `RUISC_OFF_REQ_STATUS) ? req_status_w :
        (bus_i.addr == `RUISC_OFF_EVT_STATUS) ? evt_status_w :
        (bus_i.addr == `RUISC_OFF_IRQ_ENABLE) ? {30'h0000_0000, irq_en_r} :
        (bus_i.addr == `RUISC_OFF_IRQ_SUMMARY) ? {30'h0000_0000, summary_w} :
        32'h0000_0000;

    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            rdata_r <= `RUISC_RESET_VALUE;
            irq_en_r <= 2'h0;
        end
        else if (ce_i)
        begin
            rdata_r <= bus_i.rd ? rdata_nxt : 32'h0000_0000;
            if (wr_en_w)
                irq_en_r <= bus_i.wdata[1:0];
        end
    end

    assign rdata_o = rdata_r;
endmodule

//--- hdl/ruisc_defs.svh
// What this block does
// - Each of the four request units owns one byte of the request status word, unit 0 lowest, and a zero bit means no condition seen.
// - Bit 0 of a unit's byte sets on error-free completion, only when that request asked for an interrupt.
// - Bit 1 sets on an error response or an error in the response payload of a non-posted transaction.
// - Bit 2 sets when the transaction was held back by an Xoff flow-control condition.
// - Bit 3 sets when the transaction type is unsupported or a field has an invalid encoding.
// - Bit 4 sets when the unit's transaction times out.
// - Bit 5 sets when the internal DMA transfer of the transaction's data failed.
// - Bit 6 sets on a retry answer to a doorbell or a refused test-and-swap with the semaphore in use.
// - Bit 7 sets when no outbound credit is available at the requested priority.
// - Writing ones to the write-only clear register at 0x268 clears the matching status bits, and zeros change nothing.
// - The event status register at 0x270 is read-only, resets to zero and holds bits 16, 11 to 8 and 2 to 0.
// - Bits 31 to 17 of the event status register always read zero.
// - Event bit 16 flags a device reset request, bits 11 to 8 port errors on ports 3 to 0, and bits 15 to 12 and 7 to 3 read zero.
// - Event bit 2 flags a logical-layer error capture, bit 1 a port-write-in, bit 0 a multicast-event symbol.
`ifndef RUISC_DEFS_SVH
`define RUISC_DEFS_SVH

`define RUISC_ADDR_W 12
`define RUISC_OFF_REQ_STATUS 12'h260
`define RUISC_OFF_REQ_CLEAR 12'h268
`define RUISC_OFF_EVT_STATUS 12'h270
`define RUISC_OFF_EVT_CLEAR 12'h278
`define RUISC_OFF_IRQ_ENABLE 12'h27c
`define RUISC_OFF_IRQ_SUMMARY 12'h264
`define RUISC_RESET_VALUE 32'h0000_0000
`define RUISC_EVT_MASK 32'h0001_0f07
`define RUISC_EVT_RESET_BIT 16
`define RUISC_EVT_PORT_LSB 8
`define RUISC_EVT_CAPTURE_BIT 2
`define RUISC_EVT_PWIN_BIT 1
`define RUISC_EVT_MCAST_BIT 0
`define RUISC_SUM_REQ_BIT 0
`define RUISC_SUM_EVT_BIT 1

`endif

//--- hdl/ruisc_pkg.sv
package ruisc_pkg;

    // Per-unit condition strobes, one cycle each
    typedef struct packed {
        logic no_credit;
        logic retry_or_sema;
        logic dma_error;
        logic timeout;
        logic bad_encoding;
        logic xoff;
        logic resp_error;
        logic done_ok;
    } ruisc_unit_evt_s;

    typedef struct packed {
        logic reset_req;
        logic [3:0] port_error;
        logic capture;
        logic port_write_in;
        logic mcast_event;
    } ruisc_evt_s;

    typedef struct packed {
        logic [11:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } ruisc_bus_s;

endpackage

//--- hdl/ruisc_sticky.sv
`timescale 1ns/1ps
// Bank of sticky flags; set wins over clear
module ruisc_sticky #(
    parameter int W = 8
) (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // Set and clear
    input wire logic [W-1:0] set_i,
    input wire logic [W-1:0] clr_i,
    // State
    output logic [W-1:0] flag_o
);
    logic [W-1:0] flag_r;
    logic [W-1:0] flag_nxt;

    assign flag_nxt = set_i | (flag_r & ~clr_i);
    assign flag_o = flag_r;

    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
            flag_r <= '0;
        else if (ce_i)
            flag_r <= flag_nxt;
    end
endmodule

//--- hdl/ruisc_unit.sv
`timescale 1ns/1ps
// One request unit's byte of condition flags
module ruisc_unit (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // Conditions
    input wire ruisc_pkg::ruisc_unit_evt_s evt_i,
    input wire logic irq_req_i,
    input wire logic [7:0] clr_i,
    // State
    output logic [7:0] flag_o
);
    logic [7:0] set_w;

    // Completion is reported only when the descriptor asked for it
    assign set_w[0] = evt_i.done_ok & irq_req_i;
    assign set_w[1] = evt_i.resp_error;
    assign set_w[2] = evt_i.xoff;
    assign set_w[3] = evt_i.bad_encoding;
    assign set_w[4] = evt_i.timeout;
    assign set_w[5] = evt_i.dma_error;
    assign set_w[6] = evt_i.retry_or_sema;
    assign set_w[7] = evt_i.no_credit;

    ruisc_sticky #(.W(8)) u_flags (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .set_i(set_w),
        .clr_i(clr_i),
        .flag_o(flag_o)
    );
endmodule

//--- dv/ruisc_sva.sv
`timescale 1ns/1ps
module ruisc_sva (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // Register port
    input wire ruisc_pkg::ruisc_bus_s bus_i,
    input wire logic [31:0] rdata_o,
    // Conditions and interrupt
    input wire ruisc_pkg::ruisc_unit_evt_s [3:0] unit_evt_i,
    input wire logic [3:0] unit_irq_req_i,
    input wire ruisc_pkg::ruisc_evt_s evt_i,
    input wire logic irq_o
);
    wire [31:0] setm = unit_evt_i & {7'h7f, unit_irq_req_i[3], 7'h7f, unit_irq_req_i[2],
        7'h7f, unit_irq_req_i[1], 7'h7f, unit_irq_req_i[0]};
    wire [31:0] evm = {15'h0, evt_i[7], 4'h0, evt_i[6:3], 5'h0, evt_i[2:0]};
    wire rq = ce_i && bus_i.rd && bus_i.addr == 12'h260;
    wire re = ce_i && bus_i.rd && bus_i.addr == 12'h270;
    wire wc = ce_i && bus_i.wr && bus_i.addr == 12'h268;
    wire we = ce_i && bus_i.wr && bus_i.addr == 12'h27c;
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    a_read_idle_zero: assert property (ce_i && !bus_i.rd |=> rdata_o == 32'h0)
        else $error("read data not zero when idle");
    a_evt_rsvd_zero: assert property (re |=> (rdata_o & 32'hfffe_f0f8) == 32'h0)
        else $error("reserved event bits not zero");
    a_wo_read_zero: assert property (ce_i && bus_i.rd && bus_i.addr == 12'h268 |=> rdata_o == 0)
        else $error("clear register read not zero");
    a_req_set_held: assert property (ce_i && setm != 0 ##1 rq
        |=> (rdata_o & $past(setm, 2)) == $past(setm, 2)) else $error("request flag not set");
    a_req_clear_done: assert property (wc ##1 rq && setm == 0
        |=> (rdata_o & $past(bus_i.wdata, 2) & ~$past(setm, 2)) == 0) else $error("flag not cleared");
    a_evt_set_held: assert property (ce_i && evm != 0 ##1 re
        |=> (rdata_o & $past(evm, 2)) == $past(evm, 2)) else $error("event flag not set");
    a_irq_off: assert property (we && bus_i.wdata[1:0] == 2'h0 |=> !irq_o)
        else $error("interrupt high while disabled");
    a_irq_on: assert property (we && bus_i.wdata[0] && setm != 0 |=> irq_o)
        else $error("interrupt low with enabled flag");
endmodule
bind ruisc_top ruisc_sva u_sva (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .ce_i(ce_i), .bus_i(bus_i),
    .rdata_o(rdata_o), .unit_evt_i(unit_evt_i), .unit_irq_req_i(unit_irq_req_i), .evt_i(evt_i),
    .irq_o(irq_o));

//--- dv/tb_request_unit_irq_status_clear.sv
`timescale 1ns/1ps
module tb_request_unit_irq_status_clear;
    logic sys_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic ce_i = 1'b1;
    ruisc_pkg::ruisc_bus_s bus_i = '0;
    ruisc_pkg::ruisc_unit_evt_s [3:0] unit_evt_i = '0;
    logic [3:0] unit_irq_req_i = 4'h0;
    ruisc_pkg::ruisc_evt_s evt_i = '0;
    logic [31:0] rdata_o;
    logic irq_o;
    logic [31:0] seed = 32'h78cfff87;
    logic [31:0] exp_req = 32'h0;
    logic [31:0] exp_evt = 32'h0;
    logic [31:0] c, u, q, e;
    int fail_count = 0;
    int compares = 0;
    always #5 sys_clk_i = ~sys_clk_i;
    ruisc_top DUT (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .ce_i(ce_i), .bus_i(bus_i),
        .rdata_o(rdata_o), .unit_evt_i(unit_evt_i), .unit_irq_req_i(unit_irq_req_i),
        .evt_i(evt_i), .irq_o(irq_o));
    function logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // Completion bits pass only when the descriptor asked for an interrupt
    function logic [31:0] gate(input logic [3:0] r);
        return ~32'h0101_0101 | {7'h0, r[3], 7'h0, r[2], 7'h0, r[1], 7'h0, r[0]};
    endfunction
    function logic [31:0] evmap(input logic [7:0] v);
        return {15'h0, v[7], 4'h0, v[6:3], 5'h0, v[2:0]};
    endfunction
    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        compares++;
        if (g !== x)
        begin
            fail_count++;
            $display("mismatch at %0t: got %h expected %h", $time, g, x);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [31:0] ue,
        input logic [7:0] ev);
        bus_i <= '{a, d, 1'b1, 1'b0};
        unit_evt_i <= ue;
        evt_i <= ev;
        @(posedge sys_clk_i);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] x);
        bus_i <= '{a, 32'h0, 1'b0, 1'b1};
        unit_evt_i <= '0;
        evt_i <= '0;
        @(posedge sys_clk_i);
        bus_i <= '0;
        #1 chk(rdata_o, x);
    endtask
    task automatic close_out();
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial
    begin
        #100000;
        fail_count++;
        close_out();
    end
    initial
    begin
        repeat (4) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        @(posedge sys_clk_i);
        rd(12'h270, 32'h0);
        for (int i = 0; i < 40; i++)
        begin
            c = rnd();
            q = rnd();
            e = rnd();
            // First passes fire one whole unit byte alone
            u = (i < 4) ? (32'hff << (8 * i)) : rnd();
            unit_irq_req_i <= q[3:0];
            exp_req = (exp_req & ~c) | (u & gate(q[3:0]));
            wr(12'h268, c, u, 8'h0);
            rd(12'h260, exp_req);
            exp_evt = (exp_evt & ~c) | evmap(e[7:0]);
            wr(12'h270, 32'hffff_ffff, 32'h0, 8'h0);
            wr(12'h278, c, 32'h0, e[7:0]);
            rd(12'h270, exp_evt);
            exp_req = exp_req | (u & gate(q[3:0]));
            wr(12'h27c, {30'h0, q[5:4]}, u, 8'h0);
            #1 chk({31'h0, irq_o}, {31'h0, (q[4] && exp_req != 0) || (q[5] && exp_evt != 0)});
            rd(12'h27c, {30'h0, q[5:4]});
            rd(12'h264, {30'h0, exp_evt != 0, exp_req != 0});
            rd(12'h268, 32'h0);
            rd(12'h200, 32'h0);
        end
        // Clock enable low freezes the flags against a full clear
        ce_i <= 1'b0;
        wr(12'h268, 32'hffff_ffff, 32'h0, 8'h0);
        ce_i <= 1'b1;
        rd(12'h260, exp_req);
        // Reset in mid-run empties every flag and the enables
        rst_i <= 1'b1;
        @(posedge sys_clk_i);
        rst_i <= 1'b0;
        @(posedge sys_clk_i);
        rd(12'h260, 32'h0);
        rd(12'h270, 32'h0);
        rd(12'h27c, 32'h0);
        chk({31'h0, irq_o}, 32'h0);
        close_out();
    end
endmodule
